// >>> spi_ext_pkg.sv
// Purpose: shared constants and types for the spi extender control register bank
// Assumes: 8-bit registers, 7-bit register addresses on the configuration port
// Notes: every offset, bank reset value, event and cause bit position and frame bit count lives here
`default_nettype none
package spi_ext_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [6:0] ADDR_MODE = 7'h00;
    localparam logic [6:0] ADDR_STATUS = 7'h01;
    localparam logic [6:0] ADDR_EVENT = 7'h02;
    localparam logic [6:0] ADDR_IRQEN = 7'h03;
    localparam logic [6:0] ADDR_CAUSE = 7'h04;
    localparam logic [6:0] ADDR_WLEN = 7'h05;
    localparam logic [6:0] ADDR_TEST_STORAGE = 7'h06;
    // ****************************************************************
    // reset values and field layout
    // ****************************************************************
    localparam int MODE_W = 6;
    localparam int EVT_W = 3;
    localparam int CAUSE_W = 5;
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [2:0] EVT_RST = 3'h0;
    localparam logic [2:0] IRQEN_RST = 3'h0;
    localparam logic [4:0] CAUSE_RST = 5'h00;
    localparam logic [7:0] WLEN_RST = 8'h08;
    localparam logic [7:0] WLEN_MIN = 8'h08;
    localparam logic [7:0] WLEN_MAX = 8'h20;
    localparam logic [7:0] TEST_STORAGE_RST = 8'h00;
    localparam int EVT_UP = 0;
    localparam int EVT_DOWN = 1;
    localparam int EVT_ERR = 2;
    localparam int CAUSE_WRITE = 0;
    localparam int CAUSE_LINK = 1;
    localparam int CAUSE_FAR = 2;
    localparam int CAUSE_TXOVR = 3;
    localparam int CAUSE_RXOVR = 4;
    // ****************************************************************
    // frame format and strap codes
    // ****************************************************************
    localparam logic [4:0] BITS_ADDR_LAST = 5'h07;
    localparam logic [4:0] BITS_DATA_LAST = 5'h0f;
    localparam logic [4:0] BITS_CRC_LAST = 5'h17;
    localparam logic [4:0] BITS_DATA = 5'h10;
    localparam logic [4:0] BITS_CRC = 5'h18;
    localparam logic [4:0] BITS_SAT = 5'h1f;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_HIGH = 2'h2;
    localparam logic [9:0] SYNC_RST = 10'h3_fe;
    typedef enum logic [1:0] {FR_IDLE, FR_HEAD, FR_WRITE, FR_READ} frame_state_t;
endpackage
`default_nettype wire

// >>> spi_ext_regs.sv
// Purpose: control and status register bank of a point-to-point spi extender
// Assumes: mclk at 10 MHz; configuration spi port sampled by mclk; sys_rst is the power-down pin held high
// Notes: frame engine for the configuration port, event flags, error causes, open-drain pin drives
`timescale 1ns/1ps
`default_nettype none
module spi_ext_regs
    import spi_ext_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic config_port_select_n,
    input wire logic cfg_sck,
    input wire logic cfg_mosi,
    output var logic cfg_miso,
    output var logic cfg_miso_oe,
    input wire logic link_up,
    input wire logic link_indicator_level,
    output var logic link_indicator_out,
    output var logic link_indicator_oe,
    input wire logic local_irq_level,
    output var logic local_irq_out,
    output var logic local_irq_oe,
    input wire logic far_irq_level,
    input wire logic [1:0] rate_strap_a,
    input wire logic [1:0] rate_strap_b,
    input wire logic link_corrupt,
    input wire logic far_bus_error_flag,
    input wire logic tx_overrun,
    input wire logic rx_overrun,
    output var logic far_sel1_phase,
    output var logic far_sel1_polarity,
    output var logic far_sel2_phase,
    output var logic far_sel2_polarity,
    output var logic far_sel3_phase,
    output var logic far_sel3_polarity,
    output var logic [7:0] transfer_bit_count
);
    // ****************************************************************
    // functions
    // ****************************************************************
    // crc-8, polynomial x^8+x^2+x+1, zero seed, over two bytes msb first
    function automatic logic [7:0] crc8_two(input logic [15:0] msg);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ msg[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] off);
        return a == off;
    endfunction

    // three-level straps to speed index; an illegal code counts as float
    function automatic logic [3:0] speed_index(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] sa;
        logic [1:0] sb;
        logic [3:0] idx;
        sa = (a == STRAP_LOW || a == STRAP_HIGH) ? a : STRAP_FLOAT;
        sb = (b == STRAP_LOW || b == STRAP_HIGH) ? b : STRAP_FLOAT;
        case ({sa, sb})
            {STRAP_LOW, STRAP_LOW}: idx = 4'h8;
            {STRAP_FLOAT, STRAP_LOW}: idx = 4'h7;
            {STRAP_HIGH, STRAP_LOW}: idx = 4'h6;
            {STRAP_LOW, STRAP_FLOAT}: idx = 4'h5;
            {STRAP_FLOAT, STRAP_FLOAT}: idx = 4'h4;
            {STRAP_LOW, STRAP_HIGH}: idx = 4'h3;
            {STRAP_HIGH, STRAP_FLOAT}: idx = 4'h2;
            {STRAP_FLOAT, STRAP_HIGH}: idx = 4'h1;
            default: idx = 4'h0;
        endcase
        return idx;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [9:0] sync_m_r;
    logic [9:0] sync_s_r;
    logic sck_d_r;
    logic sel_d_r;
    // only the second stage is read; straps are re-read every cycle so no capture is needed
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_m_r <= SYNC_RST;
            sync_s_r <= SYNC_RST;
        end else begin
            sync_m_r <= {rate_strap_b, rate_strap_a, far_irq_level, local_irq_level,
                         link_indicator_level, config_port_select_n, cfg_mosi, cfg_sck};
            sync_s_r <= sync_m_r;
        end
    end

    wire sck_s = sync_s_r[0];
    wire mosi_s = sync_s_r[1];
    wire sel_n_s = sync_s_r[2];
    wire link_pin_s = sync_s_r[3];
    wire lirq_pin_s = sync_s_r[4];
    wire firq_pin_s = sync_s_r[5];
    wire [1:0] strap_a_s = sync_s_r[7:6];
    wire [1:0] strap_b_s = sync_s_r[9:8];

    // edge finders work on the second stage only
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sck_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end else begin
            sck_d_r <= sck_s;
            sel_d_r <= sel_n_s;
        end
    end

    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire frame_start = ~sel_n_s & sel_d_r;
    wire frame_end = sel_n_s & ~sel_d_r;

    // ****************************************************************
    // configuration port frame engine
    // ****************************************************************
    frame_state_t state_r;
    frame_state_t state_nxt;
    logic [4:0] bitcnt_r;
    logic [7:0] rx_sh_r;
    logic [7:0] hdr_r;
    logic [7:0] dat_r;
    logic [7:0] crc_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rd_byte_r;
    logic [7:0] rd_data;

    // modes (0,0) and (1,1) only: sample on rising, shift out on falling
    wire [7:0] rx_next = {rx_sh_r[6:0], mosi_s};
    wire take_bit = sck_rise & ~sel_n_s;
    wire hdr_done = take_bit & (bitcnt_r == BITS_ADDR_LAST);
    wire data_done = take_bit & (bitcnt_r == BITS_DATA_LAST);
    wire crc_done = take_bit & (bitcnt_r == BITS_CRC_LAST);

    // header byte: address in bits 7..1, read flag in bit 0
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FR_IDLE: begin
                if (frame_start) state_nxt = FR_HEAD;
            end
            FR_HEAD: begin
                if (frame_end) state_nxt = FR_IDLE;
                else if (hdr_done) state_nxt = rx_next[0] ? FR_READ : FR_WRITE;
            end
            FR_WRITE: begin
                if (frame_end) state_nxt = FR_IDLE;
            end
            FR_READ: begin
                if (frame_end) state_nxt = FR_IDLE;
            end
            default: state_nxt = FR_IDLE;
        endcase
    end

    // receive side: bit counter saturates so long frames cannot wrap into a valid length
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= FR_IDLE;
            bitcnt_r <= 5'h00;
            rx_sh_r <= 8'h00;
            hdr_r <= 8'h00;
            dat_r <= 8'h00;
            crc_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (frame_start) begin
                bitcnt_r <= 5'h00;
            end else if (take_bit) begin
                rx_sh_r <= rx_next;
                bitcnt_r <= (bitcnt_r == BITS_SAT) ? BITS_SAT : bitcnt_r + 5'h01;
            end
            if (hdr_done) hdr_r <= rx_next;
            if (data_done) dat_r <= rx_next;
            if (crc_done) crc_r <= rx_next;
        end
    end

    // transmit side: register byte after the header, then its check byte
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_sh_r <= 8'h00;
            rd_byte_r <= 8'h00;
            cfg_miso <= 1'b0;
            cfg_miso_oe <= 1'b0;
        end else begin
            cfg_miso_oe <= ~sel_n_s;
            if (hdr_done & rx_next[0]) begin
                tx_sh_r <= rd_data;
                rd_byte_r <= rd_data;
            end else if (data_done & (state_r == FR_READ)) begin
                tx_sh_r <= crc8_two({hdr_r, rd_byte_r});
            end else if (sck_fall & (state_r == FR_READ)) begin
                cfg_miso <= tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
            if (frame_start) cfg_miso <= 1'b0;
        end
    end

    // a write commits at select release with one data byte, or with a correct check byte
    wire write_end = frame_end & (state_r == FR_WRITE);
    wire crc_ok = crc_r == crc8_two({hdr_r, dat_r});
    wire wr_ok = write_end & ((bitcnt_r == BITS_DATA) | ((bitcnt_r == BITS_CRC) & crc_ok));
    wire wr_bad = write_end & ~wr_ok;
    wire [6:0] wr_addr = hdr_r[7:1];
    wire wr_mode = wr_ok & addr_hit(wr_addr, ADDR_MODE);
    wire wr_event = wr_ok & addr_hit(wr_addr, ADDR_EVENT);
    wire wr_irqen = wr_ok & addr_hit(wr_addr, ADDR_IRQEN);
    wire wr_wlen = wr_ok & addr_hit(wr_addr, ADDR_WLEN);
    wire wr_test_storage = wr_ok & addr_hit(wr_addr, ADDR_TEST_STORAGE);
    wire wlen_legal = (dat_r >= WLEN_MIN) & (dat_r <= WLEN_MAX);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [MODE_W-1:0] mode_r;
    logic [EVT_W-1:0] evt_r;
    logic [EVT_W-1:0] irqen_r;
    logic [CAUSE_W-1:0] cause_r;
    logic [7:0] test_storage_r;
    logic link_up_d_r;

    // events from the link state and from fault sources
    wire [CAUSE_W-1:0] cause_set = {rx_overrun, tx_overrun, far_bus_error_flag, link_corrupt, wr_bad};
    wire [EVT_W-1:0] evt_set = {|cause_set, ~link_up & link_up_d_r, link_up & ~link_up_d_r};
    // only a written zero clears; a written one leaves the flag alone
    wire [EVT_W-1:0] evt_clr = wr_event ? ~dat_r[EVT_W-1:0] : {EVT_W{1'b0}};
    // set wins over a clear landing in the same cycle
    wire [EVT_W-1:0] evt_nxt = (evt_r & ~evt_clr) | evt_set;
    wire [CAUSE_W-1:0] cause_nxt = (evt_clr[EVT_ERR] ? CAUSE_RST : cause_r) | cause_set;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_r <= MODE_RST;
            evt_r <= EVT_RST;
            irqen_r <= IRQEN_RST;
            cause_r <= CAUSE_RST;
            transfer_bit_count <= WLEN_RST;
            test_storage_r <= TEST_STORAGE_RST;
            link_up_d_r <= 1'b0;
        end else begin
            link_up_d_r <= link_up;
            evt_r <= evt_nxt;
            cause_r <= cause_nxt;
            if (wr_mode) mode_r <= dat_r[MODE_W-1:0];
            if (wr_irqen) irqen_r <= dat_r[EVT_W-1:0];
            if (wr_wlen & wlen_legal) transfer_bit_count <= dat_r;
            if (wr_test_storage) test_storage_r <= dat_r;
        end
    end

    // mode outputs steer the remote master's edges and idle clock level
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {far_sel3_polarity, far_sel3_phase, far_sel2_polarity, far_sel2_phase,
             far_sel1_polarity, far_sel1_phase} <= MODE_RST;
        end else begin
            {far_sel3_polarity, far_sel3_phase, far_sel2_polarity, far_sel2_phase,
             far_sel1_polarity, far_sel1_phase} <= mode_r;
        end
    end

    // ****************************************************************
    // status view and read mux
    // ****************************************************************
    // remote interrupt level is only meaningful while the link is up
    wire [7:0] status_view = {speed_index(strap_a_s, strap_b_s), 1'b0,
                              firq_pin_s, lirq_pin_s, link_pin_s};
    wire [6:0] rd_addr = rx_next[7:1];
    assign rd_data = addr_hit(rd_addr, ADDR_MODE) ? {2'b00, mode_r} :
                     addr_hit(rd_addr, ADDR_STATUS) ? status_view :
                     addr_hit(rd_addr, ADDR_EVENT) ? {5'h00, evt_r} :
                     addr_hit(rd_addr, ADDR_IRQEN) ? {5'h00, irqen_r} :
                     addr_hit(rd_addr, ADDR_CAUSE) ? {3'h0, cause_r} :
                     addr_hit(rd_addr, ADDR_WLEN) ? transfer_bit_count :
                     addr_hit(rd_addr, ADDR_TEST_STORAGE) ? test_storage_r : 8'h00;

    // ****************************************************************
    // open-drain pin drives
    // ****************************************************************
    // local interrupt also mirrors a low remote interrupt while linked
    wire irq_pending = |(evt_r & irqen_r);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link_indicator_oe <= 1'b0;
            link_indicator_out <= 1'b0;
            local_irq_oe <= 1'b0;
            local_irq_out <= 1'b0;
        end else begin
            link_indicator_oe <= link_up;
            link_indicator_out <= 1'b0;
            local_irq_oe <= irq_pending | (link_up & ~firq_pin_s);
            local_irq_out <= 1'b0;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_zero_write_clears: assert property (wr_event && !dat_r[EVT_UP] && !evt_set[EVT_UP] |=> !evt_r[EVT_UP])
        else $error("event flag not cleared by written zero");
    a_one_write_keeps: assert property (wr_event && dat_r[EVT_UP] && evt_r[EVT_UP] |=> evt_r[EVT_UP])
        else $error("event flag lost on written one");
    a_link_up_event: assert property ($rose(link_up) |-> ##1 evt_r[EVT_UP])
        else $error("connect event not flagged");
    a_link_down_event: assert property ($fell(link_up) |-> ##1 evt_r[EVT_DOWN])
        else $error("disconnect event not flagged");
    a_error_summary: assert property (|cause_set |=> evt_r[EVT_ERR] && ((cause_r & $past(cause_set)) == $past(cause_set)))
        else $error("error cause or summary not set");
    a_summary_clears_cause: assert property (evt_clr[EVT_ERR] && cause_set == CAUSE_RST |=> cause_r == CAUSE_RST)
        else $error("cause register survived summary clear");
    a_cause_held: assert property (!evt_clr[EVT_ERR] && cause_set == CAUSE_RST |=> cause_r == $past(cause_r))
        else $error("cause register changed without cause");
    a_irq_drive: assert property (irq_pending |=> local_irq_oe)
        else $error("interrupt pin not driven");
    a_bad_write_fault: assert property (wr_bad |=> cause_r[CAUSE_WRITE] && evt_r[EVT_ERR] && mode_r == $past(mode_r))
        else $error("bad write not flagged or committed");
    a_wlen_range: assert property (transfer_bit_count >= WLEN_MIN && transfer_bit_count <= WLEN_MAX)
        else $error("word length out of range");
    a_test_storage_store: assert property (wr_test_storage |=> test_storage_r == $past(dat_r))
        else $error("test_storage byte not stored");
    a_mode_outputs: assert property (wr_mode |-> ##2 far_sel2_phase == $past(dat_r[2], 2))
        else $error("mode bit not on output");
    a_reset_defaults: assert property (disable iff (1'b0) sys_rst |=> evt_r == EVT_RST && cause_r == CAUSE_RST &&
                                       transfer_bit_count == WLEN_RST)
        else $error("register not at default after reset");

    c_read_frame: cover property (frame_end && state_r == FR_READ);
    c_good_write: cover property (wr_ok);
    c_crc_write: cover property (wr_ok && bitcnt_r == BITS_CRC);
    c_bad_write: cover property (wr_bad);
    c_irq: cover property (irq_pending ##1 evt_clr != 3'h0);
endmodule
`default_nettype wire

// >>> cfg_host_model.sv
// Purpose: host spi master model for the configuration port
// Assumes: mode (0,0), sck half period of 4 mclk (400 ns)
// Notes: sck stands low between frames; mosi flips once released
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
    input wire logic mclk,
    input wire logic miso_w,
    output var logic sel_n,
    output var logic sck,
    output var logic mosi
);
    // ****
    // frame driver
    // ****
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // bits go msb first; rd gathers the last answer byte (data, or check byte in a 24-bit read)
    // sampled late in the high half, well after the falling edge that launched it
    task automatic xfer(input logic [23:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge mclk) sel_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            mosi <= bits[23 - i];
            repeat (4) @(posedge mclk);
            sck <= 1'b1;
            repeat (4) @(posedge mclk);
            if (i >= 8 && i >= n - 8) rd = {rd[6:0], miso_w};
            sck <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        sel_n <= 1'b1;
        mosi <= ~mosi; // a released line must not keep its last value
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench for the spi extender register bank
// Assumes: 10 MHz mclk, host model on the configuration port
// Notes: open-drain pins resolved here with pull-ups
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spi_ext_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic link_up = 1'b0;
    logic far_irq_level = 1'b1;
    logic [1:0] rate_strap_a = 2'h0;
    logic [1:0] rate_strap_b = 2'h0;
    logic [3:0] fault_in = 4'h0; // rx overrun, tx overrun, far bus, corrupt
    logic miso_last = 1'b0;
    logic [7:0] x;
    wire sel_n, sck, mosi, miso, miso_oe, miso_w, lnk_out, lnk_oe, irq_out, irq_oe, link_pin, irq_pin;
    wire [5:0] far_sel;
    wire [7:0] wlen;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    // address, written byte, expected read back
    logic [22:0] rows [12] = '{{7'h00, 8'h2a, 8'h2a}, {7'h00, 8'hd5, 8'h15}, {7'h03, 8'h07, 8'h07},
        {7'h05, 8'h20, 8'h20}, {7'h05, 8'h21, 8'h20}, {7'h05, 8'h07, 8'h20}, {7'h05, 8'h08, 8'h08},
        {7'h06, 8'ha5, 8'ha5}, {7'h06, 8'h5a, 8'h5a}, {7'h04, 8'h1f, 8'h00}, {7'h10, 8'h55, 8'h00},
        {7'h03, 8'h00, 8'h00}};
    // speed index per strap pair, strap b major, low/float/high
    logic [35:0] spd = 36'h0_1324_5678;
    always #50 mclk = ~mclk;
    // ****
    // pins and instances
    // ****
    assign miso_w = miso_oe ? miso : ~miso_last;
    assign link_pin = lnk_oe ? lnk_out : 1'b1;
    assign irq_pin = irq_oe ? irq_out : 1'b1;
    always @(posedge mclk) if (miso_oe) miso_last <= miso;
    spi_ext_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .config_port_select_n(sel_n), .cfg_sck(sck),
        .cfg_mosi(mosi), .cfg_miso(miso), .cfg_miso_oe(miso_oe), .link_up(link_up),
        .link_indicator_level(link_pin), .link_indicator_out(lnk_out), .link_indicator_oe(lnk_oe),
        .local_irq_level(irq_pin), .local_irq_out(irq_out), .local_irq_oe(irq_oe),
        .far_irq_level(far_irq_level), .rate_strap_a(rate_strap_a), .rate_strap_b(rate_strap_b),
        .link_corrupt(fault_in[0]), .far_bus_error_flag(fault_in[1]), .tx_overrun(fault_in[2]),
        .rx_overrun(fault_in[3]), .far_sel1_phase(far_sel[0]), .far_sel1_polarity(far_sel[1]),
        .far_sel2_phase(far_sel[2]), .far_sel2_polarity(far_sel[3]), .far_sel3_phase(far_sel[4]),
        .far_sel3_polarity(far_sel[5]), .transfer_bit_count(wlen));
    cfg_host_model u_host (.mclk(mclk), .miso_w(miso_w), .sel_n(sel_n), .sck(sck), .mosi(mosi));
    // ****
    // helpers
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer({a, 1'b0, d, 8'h00}, 16, r);
    endtask
    task automatic chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer({a, 1'b1, 16'h0000}, 16, r);
        check(r, e);
    endtask
    // crc over header and data, own copy so a shared slip cannot hide
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic chk_defaults();
        chk(ADDR_MODE, 8'h00);
        chk(ADDR_EVENT, 8'h00);
        chk(ADDR_IRQEN, 8'h00);
        chk(ADDR_CAUSE, 8'h00);
        chk(ADDR_WLEN, 8'h08);
        chk(ADDR_TEST_STORAGE, 8'h00);
        check(wlen, 8'h08);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard: the whole sequence needs about 10800 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end
    // ****
    // main sequence
    // ****
    initial begin
        logic [7:0] c;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_defaults();
        foreach (rows[i]) begin
            wr(rows[i][22:16], rows[i][15:8]);
            chk(rows[i][22:16], rows[i][7:0]);
            if (rows[i][22:16] == ADDR_MODE) check({2'h0, far_sel}, rows[i][7:0]);
            if (rows[i][22:16] == ADDR_WLEN) check(wlen, rows[i][7:0]);
        end
        // every strap pair, link down, nothing pending
        for (int k = 0; k < 9; k++) begin
            rate_strap_a <= 2'(k % 3);
            rate_strap_b <= 2'(k / 3);
            repeat (8) @(posedge mclk);
            chk(ADDR_STATUS, {spd[k * 4 +: 4], 4'h7});
        end
        // link up and down with the up flag enabled
        link_up <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(ADDR_EVENT, 8'h01);
        wr(ADDR_IRQEN, 8'h01);
        chk(ADDR_STATUS, 8'h04);
        wr(ADDR_EVENT, 8'hff);
        chk(ADDR_EVENT, 8'h01);
        wr(ADDR_EVENT, 8'h00);
        chk(ADDR_EVENT, 8'h00);
        chk(ADDR_STATUS, 8'h06);
        far_irq_level <= 1'b0;
        chk(ADDR_STATUS, 8'h00);
        far_irq_level <= 1'b1;
        link_up <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(ADDR_EVENT, 8'h02);
        chk(ADDR_STATUS, 8'h07);
        wr(ADDR_EVENT, 8'h00);
        // one-cycle fault pulses on every cause input
        fault_in <= 4'hf;
        @(posedge mclk) fault_in <= 4'h0;
        repeat (4) @(posedge mclk);
        chk(ADDR_EVENT, 8'h04);
        wr(ADDR_CAUSE, 8'h00);
        chk(ADDR_CAUSE, 8'h1e);
        wr(ADDR_EVENT, 8'h04);
        chk(ADDR_CAUSE, 8'h1e);
        wr(ADDR_EVENT, 8'h00);
        chk(ADDR_CAUSE, 8'h00);
        // address-only write, then a wrong and a right check byte
        c = crc8({ADDR_TEST_STORAGE, 1'b0, 8'h33});
        u_host.xfer({ADDR_TEST_STORAGE, 1'b0, 8'h33, 8'h00}, 8, x);
        u_host.xfer({ADDR_TEST_STORAGE, 1'b0, 8'h33, ~c}, 24, x);
        chk(ADDR_TEST_STORAGE, 8'h5a);
        chk(ADDR_CAUSE, 8'h01);
        u_host.xfer({ADDR_TEST_STORAGE, 1'b0, 8'h33, c}, 24, x);
        chk(ADDR_TEST_STORAGE, 8'h33);
        // read with its check byte: crc over the header sent and the byte returned
        u_host.xfer({ADDR_TEST_STORAGE, 1'b1, 16'h0000}, 24, x);
        check(x, crc8({ADDR_TEST_STORAGE, 1'b1, 8'h33}));
        // power-down in mid-run with flags still set
        wr(ADDR_WLEN, 8'h20);
        wr(ADDR_MODE, 8'h3f);
        sys_rst <= 1'b1;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_defaults();
        check({2'h0, far_sel}, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
